// file: pkg/bsq_defs.svh
// Register map, reset values, factory contents and timing for the bias sequencer
`ifndef BSQ_DEFS_SVH
`define BSQ_DEFS_SVH
`define BSQ_IDX_FAULT_A 6'h01
`define BSQ_IDX_FAULT_B 6'h02
`define BSQ_IDX_OP_STATUS 6'h03
`define BSQ_IDX_RAIL_EN 6'h09
`define BSQ_IDX_BUCK_CTRL 6'h0F
`define BSQ_BIT_FA_HIGH_LOCK 0
`define BSQ_BIT_FB_OCP 2
`define BSQ_BIT_FB_OVP 1
`define BSQ_BIT_FB_UVP 0
`define BSQ_BIT_RE_BUCK 1
`define BSQ_BIT_BC_FULL_DUTY 7
`define BSQ_BIT_BC_SPREAD 6
`define BSQ_BIT_BC_FORCED_CONTINUOUS_MODE 5
`define BSQ_BIT_OS_PG 0
`define BSQ_BIT_OS_SS 1
`define BSQ_BIT_OS_BUCK 2
`define BSQ_BIT_OS_SKIP 3
`define BSQ_BIT_OS_FULL_DUTY 5
`define BSQ_RST_RAIL_EN 8'h00
`define BSQ_RST_BUCK_CTRL 8'h00
`define BSQ_RST_TRIM 8'h00
`define BSQ_ROM_WORDS 3
`define BSQ_ROM_RAIL_EN 8'h03
`define BSQ_ROM_BUCK_CTRL 8'h20
`define BSQ_ROM_TRIM 8'h5A
`define BSQ_CLK_NS 25
`define BSQ_SS_TIME_US 1000
`define BSQ_BIAS_SETTLE_NS 10000
`define BSQ_TON_NS 200
`define BSQ_MIN_OFF_NS 75
`define BSQ_SW_PERIOD_NS 500
`define BSQ_DITHER_PERIODS 16
`define BSQ_REV_CYCLES 4
`define BSQ_SS_STEPS 256
`endif

// file: pkg/bsq_pkg.sv
// Types shared by the bias sequencer
package bsq_pkg;
  typedef enum logic [2:0] {
    ST_LOW_LOCK,
    ST_HIGH_LOCK,
    ST_ROM_LOAD,
    ST_BIAS,
    ST_RUN
  } bsq_state_t;
endpackage

// file: design/bsq_softstart.sv
// Soft-start reference ramp with pre-biased output hold-off
`timescale 1ns/1ps
`include "bsq_defs.svh"
module bsq_softstart #(
  parameter int SS_CYCLES = 40000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic rail_above_ref_i,
  output logic [7:0] ref_o,
  output logic active_o,
  output logic inhibit_o
);
  localparam int STEP_CYC = (SS_CYCLES / `BSQ_SS_STEPS) < 1 ? 1 : SS_CYCLES / `BSQ_SS_STEPS;
  logic en_q;
  logic [15:0] step_q;
  logic hold_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
    end else begin
      en_q <= en_i;
    end
  end

  // Every enable edge restarts the full ramp from zero
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      ref_o <= 8'h00;
      active_o <= 1'b0;
      step_q <= 16'h0000;
    end else if (!en_q) begin
      ref_o <= 8'h00; // RULE11 RULE23
      active_o <= 1'b1;
      step_q <= 16'h0000;
    end else if (active_o) begin
      if (step_q == 16'(STEP_CYC - 1)) begin
        step_q <= 16'h0000;
        if (ref_o == 8'hFF) begin
          active_o <= 1'b0;
        end else begin
          ref_o <= ref_o + 8'h01; // RULE11
        end
      end else begin
        step_q <= step_q + 16'h0001;
      end
    end
  end

  // Hold switching off until the rising reference first reaches the output; the hold stays released until the next enable
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      hold_q <= 1'b1;
    end else if (!en_q) begin
      hold_q <= 1'b1;
    end else if (!rail_above_ref_i) begin
      hold_q <= 1'b0; // RULE13
    end
  end
  assign inhibit_o = hold_q || !en_q;

  property p_ss_restart;
    @(posedge clk_i) disable iff (rst_i) $rose(en_i) |=> ##1 (ref_o == 8'h00 && active_o);
  endproperty
  a_ss_restart: assert property (p_ss_restart) else $error("ramp did not restart"); // RULE11

  property p_ss_prebias;
    @(posedge clk_i) disable iff (rst_i)
      (en_q && hold_q && rail_above_ref_i) |=> inhibit_o;
  endproperty
  a_ss_prebias: assert property (p_ss_prebias) else $error("switching before ref"); // RULE13
endmodule

// file: design/bsq_switch_ctrl.sv
// Fixed on-time switch timing with skip, full duty and dither
`timescale 1ns/1ps
`include "bsq_defs.svh"
module bsq_switch_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic inhibit_i,
  input wire logic forced_continuous_mode_i,
  input wire logic full_duty_en_i,
  input wire logic spread_i,
  input wire logic fb_low_i,
  input wire logic rev_cur_i,
  output logic hs_o,
  output logic ls_o,
  output logic full_duty_o,
  output logic skip_o
);
  localparam int TON_CYC = (`BSQ_TON_NS + `BSQ_CLK_NS - 1) / `BSQ_CLK_NS;
  localparam int MINOFF_CYC = (`BSQ_MIN_OFF_NS + `BSQ_CLK_NS - 1) / `BSQ_CLK_NS;
  localparam int PER_CYC = `BSQ_SW_PERIOD_NS / `BSQ_CLK_NS;
  logic [7:0] tmr_q;
  logic [7:0] per_cnt_q;
  logic [2:0] rev_cnt_q;
  logic rev_seen_q;
  logic [7:0] off_len;
  logic start_on;
  logic run;

  assign run = en_i && !inhibit_i;
  // Dither offset walks 0..3 cycles and wraps with the period counter
  assign off_len = 8'(PER_CYC - TON_CYC) + (spread_i ? {6'h00, per_cnt_q[3:2]} : 8'h00); // RULE20
  assign start_on = !hs_o
    && (full_duty_en_i || tmr_q >= 8'(MINOFF_CYC - 1)) // RULE17 RULE18
    && (fb_low_i || (forced_continuous_mode_i && tmr_q >= off_len - 8'h01)); // RULE14

  always_ff @(posedge clk_i) begin
    if (rst_i || !run) begin
      hs_o <= 1'b0;
      tmr_q <= 8'h00;
      full_duty_o <= 1'b0;
    end else if (hs_o) begin
      if (tmr_q >= 8'(TON_CYC - 1)) begin
        if (full_duty_en_i && fb_low_i) begin
          full_duty_o <= 1'b1; // RULE18
        end else begin
          hs_o <= 1'b0;
          full_duty_o <= 1'b0;
          tmr_q <= 8'h00;
        end
      end else begin
        tmr_q <= tmr_q + 8'h01;
      end
    end else if (start_on) begin
      hs_o <= 1'b1;
      tmr_q <= 8'h00;
    end else if (tmr_q != 8'hFF) begin
      tmr_q <= tmr_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !run) begin
      per_cnt_q <= 8'h00;
    end else if (start_on) begin
      per_cnt_q <= (per_cnt_q == 8'(`BSQ_DITHER_PERIODS - 1)) ? 8'h00 : per_cnt_q + 8'h01; // RULE21
    end
  end

  // Count consecutive periods that saw reverse current
  always_ff @(posedge clk_i) begin
    if (rst_i || !run || forced_continuous_mode_i) begin
      rev_seen_q <= 1'b0;
      rev_cnt_q <= 3'h0;
    end else if (start_on) begin
      rev_seen_q <= 1'b0;
      if (!rev_seen_q) begin
        rev_cnt_q <= 3'h0;
      end else if (rev_cnt_q != 3'(`BSQ_REV_CYCLES)) begin
        rev_cnt_q <= rev_cnt_q + 3'h1;
      end
    end else if (rev_cur_i) begin
      rev_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ls_o <= 1'b0;
      skip_o <= 1'b0;
    end else begin
      skip_o <= !forced_continuous_mode_i && rev_cnt_q == 3'(`BSQ_REV_CYCLES); // RULE15
      ls_o <= run && !hs_o && !start_on && !(skip_o && rev_cur_i); // RULE15
    end
  end

  property p_no_overlap;
    @(posedge clk_i) disable iff (rst_i) hs_o |=> !ls_o;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("switch overlap"); // RULE17

  property p_min_off;
    @(posedge clk_i) disable iff (rst_i)
      (!full_duty_en_i && $fell(hs_o)) |-> !hs_o [*2];
  endproperty
  a_min_off: assert property (p_min_off) else $error("minimum off skipped"); // RULE17
endmodule

// file: design/bsq_top.sv
// Bias rail start-up sequencer with lockouts, factory load and Wishbone registers
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`include "bsq_defs.svh"
// What this block does
// RULE1 - Below rising low-input threshold, everything stays off except the input monitor.
// RULE2 - Once running, stop only when input drops under the lower falling threshold.
// RULE3 - Input over high threshold stops all; resume after it falls below release.
// RULE4 - Recovering from high-input lockout sets fault_status_a bit 0.
// RULE5 - First sequencer step after lockout release loads factory configuration memory. After a high-input lockout the code skips the load if it already ran.
// RULE6 - Factory contents become the default values of software registers.
// RULE7 - Bias and references come up before the auxiliary buck starts.
// RULE8 - By default the buck starts once both lockouts clear and stays on.
// RULE9 - Clearing rail_enable_ctrl bit 1 turns the auxiliary buck off.
// RULE10 - Rail good comparator is watched always and feeds bias-ready.
// RULE11 - Each buck enable ramps the reference from zero to full over soft-start.
// RULE12 - Soft-start forces pulse-skip and ignores bias_buck_ctrl bit 5.
// RULE13 - Into a pre-charged output, no switching until the reference reaches it.
// RULE14 - bias_buck_ctrl bit 5 high selects forced continuous at fixed frequency.
// RULE15 - Bit 5 low selects pulse-skip, blocking reverse current after repeated cycles.
// RULE16 - bias_buck_ctrl bit 7 enables full-duty operation.
// RULE17 - Without full duty, each cycle keeps a minimum off time.
// RULE18 - With full duty, high side stays on across cycles while feedback is low.
// RULE19 - operating_status bit 5 shows full-duty operation.
// RULE20 - bias_buck_ctrl bit 6 enables spread-spectrum frequency dither.
// RULE21 - Dither pattern repeats every fixed number of switching periods.
// RULE22 - fault_status_b bits 2,1,0 flag rail overcurrent, overvoltage, undervoltage.
// RULE23 - Re-enabling the buck reruns the whole soft-start ramp.
module bsq_top
  import bsq_pkg::*;
#(
  parameter int SS_CYCLES = `BSQ_SS_TIME_US * 1000 / `BSQ_CLK_NS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic vin_above_rise_i,
  input wire logic vin_above_fall_i,
  input wire logic vin_above_high_i,
  input wire logic vin_above_high_rel_i,
  input wire logic rail_good_i,
  input wire logic rail_above_ref_i,
  input wire logic fb_low_i,
  input wire logic rev_cur_i,
  input wire logic rail_ocp_i,
  input wire logic rail_ovp_i,
  input wire logic rail_uvp_i,
  output logic seq_active_o,
  output logic bias_en_o,
  output logic buck_en_o,
  output logic bias_ready_o,
  output logic [7:0] trim_o,
  output logic [7:0] ss_ref_o,
  output logic hs_on_o,
  output logic ls_on_o
);
  localparam int NPIN = 11;
  localparam int BIAS_CYC = (`BSQ_BIAS_SETTLE_NS + `BSQ_CLK_NS - 1) / `BSQ_CLK_NS;
  localparam logic [7:0] ROM [`BSQ_ROM_WORDS] = '{
    `BSQ_ROM_RAIL_EN, `BSQ_ROM_BUCK_CTRL, `BSQ_ROM_TRIM
  };

  function automatic logic hit(input logic [7:0] adr, input logic [5:0] idx);
    hit = (adr[7:2] == idx) && (adr[1:0] == 2'b00);
  endfunction

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] meta_q;
  logic [NPIN-1:0] pin_q;
  logic v_rise;
  logic v_fall;
  logic v_high;
  logic v_high_rel;
  logic pg;
  bsq_state_t state_q;
  bsq_state_t state_d;
  logic rom_done_q;
  logic [1:0] rom_idx_q;
  logic [15:0] bias_cnt_q;
  logic [7:0] fault_a_q;
  logic [7:0] fault_b_q;
  logic [7:0] rail_en_q;
  logic [7:0] buck_ctrl_q;
  logic wr_en;
  logic rd_en;
  logic [7:0] clr_a;
  logic [7:0] clr_b;
  logic [7:0] rd_byte;
  logic [7:0] op_status;
  logic ss_active;
  logic sw_inhibit;
  logic full_duty;
  logic skip_mode;
  logic high_exit;

  assign pin_raw = {rail_uvp_i, rail_ovp_i, rail_ocp_i, rev_cur_i, fb_low_i,
    rail_above_ref_i, rail_good_i, vin_above_high_rel_i, vin_above_high_i,
    vin_above_fall_i, vin_above_rise_i};

  // Comparator outputs are asynchronous to the oscillator
  generate
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_q[i] <= 1'b0;
          pin_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= pin_raw[i];
          pin_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign v_rise = pin_q[0];
  assign v_fall = pin_q[1];
  assign v_high = pin_q[2];
  assign v_high_rel = pin_q[3];
  assign pg = pin_q[4];
  assign high_exit = state_q == ST_HIGH_LOCK && !v_high_rel && v_fall;

  // Sequencer; falling below the low threshold wins over every other state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_LOW_LOCK: begin
        if (v_rise) begin
          state_d = ST_ROM_LOAD; // RULE1 RULE5
        end
      end
      ST_HIGH_LOCK: begin
        if (!v_high_rel) begin
          state_d = rom_done_q ? ST_BIAS : ST_ROM_LOAD; // RULE3
        end
      end
      ST_ROM_LOAD: begin
        if (rom_idx_q == 2'(`BSQ_ROM_WORDS - 1)) begin
          state_d = ST_BIAS; // RULE7
        end
      end
      ST_BIAS: begin
        if (bias_cnt_q == 16'(BIAS_CYC - 1)) begin
          state_d = ST_RUN; // RULE7 RULE8
        end
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
    endcase
    if (state_q != ST_LOW_LOCK && state_q != ST_HIGH_LOCK && v_high) begin
      state_d = ST_HIGH_LOCK; // RULE3
    end
    if (state_q != ST_LOW_LOCK && !v_fall) begin
      state_d = ST_LOW_LOCK; // RULE2
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_LOW_LOCK;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != ST_ROM_LOAD) begin
      rom_idx_q <= 2'h0;
    end else begin
      rom_idx_q <= rom_idx_q + 2'h1;
    end
  end

  // A low-input lockout forces a fresh factory load on the next start
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q == ST_LOW_LOCK) begin
      rom_done_q <= 1'b0;
    end else if (state_q == ST_ROM_LOAD && state_d == ST_BIAS) begin
      rom_done_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != ST_BIAS) begin
      bias_cnt_q <= 16'h0000;
    end else begin
      bias_cnt_q <= bias_cnt_q + 16'h0001;
    end
  end

  // Wishbone classic slave, answers every access one cycle later
  assign wr_en = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  assign rd_en = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (hit(wb_adr_i, `BSQ_IDX_FAULT_A)) begin
      rd_byte = fault_a_q;
    end else if (hit(wb_adr_i, `BSQ_IDX_FAULT_B)) begin
      rd_byte = fault_b_q;
    end else if (hit(wb_adr_i, `BSQ_IDX_OP_STATUS)) begin
      rd_byte = op_status;
    end else if (hit(wb_adr_i, `BSQ_IDX_RAIL_EN)) begin
      rd_byte = rail_en_q;
    end else if (hit(wb_adr_i, `BSQ_IDX_BUCK_CTRL)) begin
      rd_byte = buck_ctrl_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_en) begin
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // Control registers: factory values first, software may overwrite later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rail_en_q <= `BSQ_RST_RAIL_EN;
      buck_ctrl_q <= `BSQ_RST_BUCK_CTRL;
      trim_o <= `BSQ_RST_TRIM;
    end else if (state_q == ST_ROM_LOAD) begin
      unique case (rom_idx_q)
        2'h0: rail_en_q <= ROM[0]; // RULE6
        2'h1: buck_ctrl_q <= ROM[1]; // RULE6
        2'h2: trim_o <= ROM[2]; // RULE5
        default: trim_o <= trim_o;
      endcase
    end else if (wr_en && hit(wb_adr_i, `BSQ_IDX_RAIL_EN)) begin
      rail_en_q <= wb_dat_i[7:0]; // RULE9
    end else if (wr_en && hit(wb_adr_i, `BSQ_IDX_BUCK_CTRL)) begin
      buck_ctrl_q <= wb_dat_i[7:0]; // RULE14 RULE16 RULE20
    end
  end

  // Fault flags clear on write of one; a new event in the same cycle wins
  assign clr_a = (wr_en && hit(wb_adr_i, `BSQ_IDX_FAULT_A)) ? wb_dat_i[7:0] : 8'h00;
  assign clr_b = (wr_en && hit(wb_adr_i, `BSQ_IDX_FAULT_B)) ? wb_dat_i[7:0] : 8'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_a_q <= 8'h00;
      fault_b_q <= 8'h00;
    end else begin
      fault_a_q <= (fault_a_q & ~clr_a) | {7'h00, high_exit}; // RULE4
      fault_b_q <= (fault_b_q & ~clr_b)
        | {5'h00, pin_q[8] && buck_en_o, pin_q[9] && buck_en_o,
           pin_q[10] && buck_en_o && !ss_active}; // RULE22
    end
  end

  assign op_status = {2'b00, full_duty, 1'b0, skip_mode, buck_en_o, ss_active, pg}; // RULE19

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_active_o <= 1'b0;
      bias_en_o <= 1'b0;
      buck_en_o <= 1'b0;
      bias_ready_o <= 1'b0;
    end else begin
      seq_active_o <= state_d != ST_LOW_LOCK && state_d != ST_HIGH_LOCK; // RULE1 RULE3
      bias_en_o <= state_d == ST_BIAS || state_d == ST_RUN; // RULE7
      buck_en_o <= state_d == ST_RUN && rail_en_q[`BSQ_BIT_RE_BUCK]; // RULE8 RULE9
      bias_ready_o <= state_q == ST_RUN && pg; // RULE10
    end
  end

  bsq_softstart #(
    .SS_CYCLES(SS_CYCLES)
  ) u_ss (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(buck_en_o),
    .rail_above_ref_i(pin_q[5]),
    .ref_o(ss_ref_o),
    .active_o(ss_active),
    .inhibit_o(sw_inhibit)
  );

  bsq_switch_ctrl u_sw (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(buck_en_o),
    .inhibit_i(sw_inhibit),
    .forced_continuous_mode_i(buck_ctrl_q[`BSQ_BIT_BC_FORCED_CONTINUOUS_MODE] && !ss_active), // RULE12
    .full_duty_en_i(buck_ctrl_q[`BSQ_BIT_BC_FULL_DUTY]), // RULE16
    .spread_i(buck_ctrl_q[`BSQ_BIT_BC_SPREAD]),
    .fb_low_i(pin_q[6]),
    .rev_cur_i(pin_q[7]),
    .hs_o(hs_on_o),
    .ls_o(ls_on_o),
    .full_duty_o(full_duty),
    .skip_o(skip_mode)
  );

  property p_low_lock_off;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == ST_LOW_LOCK) |-> (!bias_en_o && !buck_en_o && !seq_active_o);
  endproperty
  a_low_lock_off: assert property (p_low_lock_off) else $error("active in low lockout"); // RULE1

  property p_high_fault;
    @(posedge clk_i) disable iff (rst_i) high_exit |=> fault_a_q[0];
  endproperty
  a_high_fault: assert property (p_high_fault) else $error("high lockout flag missing"); // RULE4

  property p_buck_off;
    @(posedge clk_i) disable iff (rst_i)
      !rail_en_q[`BSQ_BIT_RE_BUCK] |=> !buck_en_o;
  endproperty
  a_buck_off: assert property (p_buck_off) else $error("buck on while disabled"); // RULE9

  property p_bias_first;
    @(posedge clk_i) disable iff (rst_i) $rose(buck_en_o) |-> $past(bias_en_o, 2);
  endproperty
  a_bias_first: assert property (p_bias_first) else $error("buck before bias"); // RULE7

  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack timing wrong");
endmodule

// file: verif/bsq_supply_model.sv
// Behavioural input supply and bias rail power stage around the sequencer
`timescale 1ns/1ps
module bsq_supply_model #(
  parameter int RISE_MV = 4300,
  parameter int FALL_MV = 4000,
  parameter int HIGH_MV = 42000,
  parameter int HREL_MV = 41000
) (
  input wire logic clk_i,
  input wire logic [15:0] vin_mv_i,
  input wire logic ext_5v_i,
  input wire logic fb_force_i,
  input wire logic light_load_i,
  input wire logic hs_on_i,
  input wire logic ls_on_i,
  input wire logic [7:0] ss_ref_i,
  output logic vin_above_rise_o,
  output logic vin_above_fall_o,
  output logic vin_above_high_o,
  output logic vin_above_high_rel_o,
  output logic rail_good_o,
  output logic rail_above_ref_o,
  output logic fb_low_o,
  output logic rev_cur_o
);
  logic [7:0] rail_q = 8'h00;
  logic [1:0] load_q = 2'h0;
  assign vin_above_rise_o = int'(vin_mv_i) > RISE_MV;
  assign vin_above_fall_o = int'(vin_mv_i) > FALL_MV;
  assign vin_above_high_o = int'(vin_mv_i) > HIGH_MV;
  assign vin_above_high_rel_o = int'(vin_mv_i) > HREL_MV;
  // Steady load drains the rail unless ext_5v_i pins it, so switching never stops for good
  always @(posedge clk_i) begin
    load_q <= load_q + 2'h1;
    if (ext_5v_i) begin
      rail_q <= 8'hE0;
    end else if (hs_on_i && rail_q < 8'hFE) begin
      rail_q <= rail_q + 8'h02;
    end else if (load_q == 2'h0 && rail_q != 8'h00) begin
      rail_q <= rail_q - 8'h01;
    end
  end
  assign rail_good_o = rail_q >= 8'hC0;
  assign rail_above_ref_o = rail_q > ss_ref_i;
  assign fb_low_o = fb_force_i || rail_q < 8'hD0;
  // Light load turns the coil current round while the low side conducts
  assign rev_cur_o = light_load_i && ls_on_i;
endmodule

// file: verif/bsq_top_tb_top.sv
// Self-checking bench for the bias rail start-up sequencer
`timescale 1ns/1ps
module bsq_top_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, wb_dat_o;
  logic wb_ack_o, ocp = 1'b0, ovp = 1'b0, uvp = 1'b0, ext = 1'b0, fbf = 1'b0, light = 1'b0;
  logic [15:0] input_supply_pin = 16'd3000;
  logic rise, fall, high, hrel, good, above, fbl, rev;
  logic seq_active_o, bias_en_o, buck_en_o, bias_ready_o, hs_on_o, ls_on_o;
  logic [7:0] trim_o, ss_ref_o, rd;
  int mismatches = 0, compares = 0, cycles = 0, n;

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  bsq_top #(.SS_CYCLES(512)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .vin_above_rise_i(rise),
    .vin_above_fall_i(fall), .vin_above_high_i(high), .vin_above_high_rel_i(hrel),
    .rail_good_i(good), .rail_above_ref_i(above), .fb_low_i(fbl), .rev_cur_i(rev),
    .rail_ocp_i(ocp), .rail_ovp_i(ovp), .rail_uvp_i(uvp), .seq_active_o(seq_active_o),
    .bias_en_o(bias_en_o), .buck_en_o(buck_en_o), .bias_ready_o(bias_ready_o),
    .trim_o(trim_o), .ss_ref_o(ss_ref_o), .hs_on_o(hs_on_o), .ls_on_o(ls_on_o));

  bsq_supply_model i_far (.clk_i(clk_i), .vin_mv_i(input_supply_pin), .ext_5v_i(ext), .fb_force_i(fbf),
    .light_load_i(light), .hs_on_i(hs_on_o), .ls_on_i(ls_on_o), .ss_ref_i(ss_ref_o),
    .vin_above_rise_o(rise), .vin_above_fall_o(fall), .vin_above_high_o(high),
    .vin_above_high_rel_o(hrel), .rail_good_o(good), .rail_above_ref_o(above),
    .fb_low_o(fbl), .rev_cur_o(rev));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // One classic cycle; request held until the edge that samples ack
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    chk("bus ack", n, 2);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    wb(a, 1'b0, 8'h00);
    chk(what, {24'h0, rd}, {24'h0, exp});
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return seq_active_o;
      1: return bias_en_o;
      2: return buck_en_o;
      3: return hs_on_o;
      default: return ss_ref_o == 8'hFF;
    endcase
  endfunction

  task automatic wait_sig(input int k, input logic v, input int lim);
    n = 0;
    while (sig(k) !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= lim) chk($sformatf("wait on %0d", k), 0, 1);
  endtask

  task automatic t_low_lockout;
    repeat (20) @(posedge clk_i);
    chk("active", seq_active_o, 0);
    chk("bias", {bias_en_o, buck_en_o, hs_on_o}, 0);
    rdchk(8'h24, 8'h00, "rail_en reset");
    rdchk(8'h10, 8'h00, "unmapped");
    rdchk(8'h25, 8'h00, "misaligned");
    $display("test low lockout done");
  endtask

  task automatic t_powerup;
    input_supply_pin <= 16'd12000;
    wait_sig(0, 1'b1, 10);
    chk("bias in load", bias_en_o, 0);
    wait_sig(1, 1'b1, 10);
    chk("buck before bias", buck_en_o, 0);
    wait_sig(2, 1'b1, 600);
    chk("trim", trim_o, 8'h5A);
    chk("ramp start", ss_ref_o < 8'h08, 1);
    rdchk(8'h24, 8'h03, "rail_en rom");
    rdchk(8'h3C, 8'h20, "buck_ctrl rom");
    rdchk(8'h0C, 8'h06, "status ss");
    // Forced continuous is set by the factory word, yet the ramp must still skip
    light <= 1'b1;
    repeat (100) @(posedge clk_i);
    wb(8'h0C, 1'b0, 8'h00);
    light <= 1'b0;
    chk("skip in ramp", rd[3], 1);
    wait_sig(4, 1'b1, 700);
    repeat (10) @(posedge clk_i);
    $display("test power-up done");
  endtask

  task automatic t_hysteresis;
    input_supply_pin <= 16'd4100;
    repeat (20) @(posedge clk_i);
    chk("hold in band", seq_active_o, 1);
    input_supply_pin <= 16'd3000;
    wait_sig(0, 1'b0, 10);
    chk("buck off", buck_en_o, 0);
    input_supply_pin <= 16'd4100;
    repeat (20) @(posedge clk_i);
    chk("no restart in band", seq_active_o, 0);
    input_supply_pin <= 16'd12000;
    wait_sig(2, 1'b1, 600);
    $display("test hysteresis done");
  endtask

  task automatic t_high_lockout;
    input_supply_pin <= 16'd45000;
    wait_sig(0, 1'b0, 10);
    chk("high off", {bias_en_o, buck_en_o}, 0);
    input_supply_pin <= 16'd41500;
    repeat (20) @(posedge clk_i);
    chk("high band", seq_active_o, 0);
    input_supply_pin <= 16'd12000;
    wait_sig(2, 1'b1, 600);
    rdchk(8'h04, 8'h01, "fault_a");
    wb(8'h04, 1'b1, 8'h01);
    rdchk(8'h04, 8'h00, "fault_a clear");
    wait_sig(4, 1'b1, 700);
    repeat (10) @(posedge clk_i);
    $display("test high lockout done");
  endtask

  task automatic t_faults;
    ocp <= 1'b1;
    repeat (6) @(posedge clk_i);
    ocp <= 1'b0;
    rdchk(8'h08, 8'h04, "ocp");
    ovp <= 1'b1;
    repeat (6) @(posedge clk_i);
    ovp <= 1'b0;
    rdchk(8'h08, 8'h06, "ovp");
    uvp <= 1'b1;
    repeat (6) @(posedge clk_i);
    uvp <= 1'b0;
    rdchk(8'h08, 8'h07, "uvp");
    wb(8'h08, 1'b1, 8'h07);
    rdchk(8'h08, 8'h00, "fault_b clear");
    $display("test faults done");
  endtask

  task automatic t_ext_rail;
    ext <= 1'b1;
    wb(8'h24, 1'b1, 8'h01);
    wait_sig(2, 1'b0, 5);
    repeat (30) @(posedge clk_i);
    chk("off switch", hs_on_o, 0);
    chk("rail good kept", bias_ready_o, 1);
    wb(8'h24, 1'b1, 8'h03);
    wait_sig(2, 1'b1, 5);
    chk("ramp restart", ss_ref_o < 8'h08, 1);
    n = 0;
    while (ss_ref_o < 8'hD0) begin
      @(posedge clk_i);
      if (hs_on_o !== 1'b0) n++;
    end
    chk("prebias hold", n, 0);
    wait_sig(4, 1'b1, 700);
    ext <= 1'b0;
    repeat (10) @(posedge clk_i);
    $display("test external rail done");
  endtask

  task automatic t_modes;
    int per [32];
    int diff;
    wb(8'h3C, 1'b1, 8'hA0);
    fbf <= 1'b1;
    // Let the forced feedback pass the input synchroniser first
    repeat (4) @(posedge clk_i);
    wait_sig(3, 1'b1, 40);
    n = 0;
    repeat (60) begin
      @(posedge clk_i);
      if (hs_on_o !== 1'b1) n++;
    end
    chk("full duty on", n, 0);
    rdchk(8'h0C, 8'h25, "status full");
    wb(8'h3C, 1'b1, 8'h20);
    n = 0;
    repeat (40) begin
      @(posedge clk_i);
      if (ls_on_o === 1'b1) n++;
    end
    chk("min off", n > 0, 1);
    fbf <= 1'b0;
    wb(8'h3C, 1'b1, 8'h60);
    rdchk(8'h3C, 8'h60, "spread");
    wait_sig(3, 1'b1, 400);
    wait_sig(3, 1'b0, 40);
    wait_sig(3, 1'b1, 40);
    // Rail sits above target here, so only the period timer starts pulses
    for (int k = 0; k < 32; k++) begin
      per[k] = 0;
      do begin
        @(posedge clk_i);
        per[k]++;
      end while (hs_on_o !== 1'b0 && per[k] < 100);
      do begin
        @(posedge clk_i);
        per[k]++;
      end while (hs_on_o !== 1'b1 && per[k] < 100);
    end
    chk("forced_continuous_mode period", per[0] < 30, 1);
    diff = 0;
    for (int k = 0; k < 16; k++) begin
      chk("dither repeat", per[k], per[k + 16]);
      if (per[k] != per[0]) diff++;
    end
    chk("dither spread", diff > 0, 1);
    wb(8'h3C, 1'b1, 8'h00);
    light <= 1'b1;
    // Rail must drain to target before four reverse-current periods can pass
    repeat (800) @(posedge clk_i);
    wb(8'h0C, 1'b0, 8'h00);
    chk("skip", rd[3], 1);
    light <= 1'b0;
    $display("test modes done");
  endtask

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole run needs about 5000 cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_low_lockout();
    t_powerup();
    t_hysteresis();
    t_high_lockout();
    t_faults();
    t_ext_rail();
    t_modes();
    tally_and_finish();
  end
endmodule
